// file: verilog/sensor_serial_port.sv
// Serial port core with power state timing and Avalon-MM access
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "sensor_serial_cfg.svh"
module sensor_serial_port #(
  parameter int unsigned P_MOT_RST_CYC  = `CFG_MOT_RST_CYC,
  parameter int unsigned P_REST_EN_CYC  = `CFG_REST_EN_CYC,
  parameter int unsigned P_REST_DIS_CYC = `CFG_REST_DIS_CYC,
  parameter int unsigned P_PD_CYC       = `CFG_PD_CYC,
  parameter int unsigned P_WAKE_CYC     = `CFG_WAKE_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_clk_en,
  input  wire logic        i_sclk,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_mosi,
  output logic             o_miso,
  output logic             o_miso_oe_n,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_motion_valid,
  output logic             o_low_current,
  output logic             o_rest_active
);
  // Maximum waits shed the crossing latency so the limit holds end to end
  localparam logic [26:0] LD_MOT_RST  = 27'(P_MOT_RST_CYC - `CFG_SYNC_MARGIN);
  localparam logic [26:0] LD_REST_EN  = 27'(P_REST_EN_CYC - `CFG_SYNC_MARGIN);
  localparam logic [26:0] LD_REST_DIS = 27'(P_REST_DIS_CYC - `CFG_SYNC_MARGIN);
  localparam logic [26:0] LD_PD       = 27'(P_PD_CYC - `CFG_SYNC_MARGIN);
  // Minimum wait is counted in full, the crossing only adds to it
  localparam logic [26:0] LD_WAKE     = 27'(P_WAKE_CYC);

  localparam sensor_serial_pkg::core_t CORE_RST = '{
    st:           sensor_serial_pkg::PWR_RESETTING,
    cnt:          LD_MOT_RST,
    pc:           `CFG_PC_RESET,
    ctrl:         `CFG_CONTROL_RESET,
    wr_sync:      3'h0,
    rd_sync:      3'h0,
    av:           sensor_serial_pkg::AV_IDLE,
    rd_pend:      1'b0,
    rd_hold:      8'h00,
    av_rdata:     32'h0000_0000,
    last_wr:      7'h00,
    motion_valid: 1'b0,
    low_current:  1'b0,
    rest_active:  1'b0
  };

  function automatic logic reg_hit(input logic [6:0] a, input logic [6:0] r);
    reg_hit = (a == r);
  endfunction

  sensor_serial_pkg::core_t s_q;
  sensor_serial_pkg::core_t s_d;

  logic       link_wr_tog;
  logic [6:0] link_wr_addr;
  logic [7:0] link_wr_data;
  logic       link_rd_tog;
  logic [6:0] link_rd_addr;
  logic       mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic       spi_wr;
  logic       spi_rd;
  logic       wr_go;
  logic [6:0] wr_a;
  logic [7:0] wr_v;
  logic       av_req;
  logic       av_own;
  logic [31:0] status_word;

  sensor_serial_link u_link (
    .i_sclk          (i_sclk),
    .i_reset         (i_reset),
    .i_chip_select_n (i_chip_select_n),
    .i_mosi          (i_mosi),
    .i_rd_data       (s_q.rd_hold),
    .o_miso          (o_miso),
    .o_miso_oe_n     (o_miso_oe_n),
    .o_wr_toggle     (link_wr_tog),
    .o_wr_addr       (link_wr_addr),
    .o_wr_data       (link_wr_data),
    .o_rd_toggle     (link_rd_tog),
    .o_rd_addr       (link_rd_addr)
  );

  sensor_serial_mem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_clk_en  (i_clk_en),
    .i_wr_en   (mem_we),
    .i_addr    (mem_addr),
    .i_wr_data (mem_wdata),
    .o_rd_data (mem_rdata)
  );

  assign av_req = i_avs_read | i_avs_write;
  assign av_own = i_avs_address[`CFG_AV_OWN_BIT];
  assign status_word = {16'h0000, 1'b0, s_q.last_wr, 4'h0, (s_q.cnt != 27'h000_0000),
                        s_q.rest_active, s_q.low_current, s_q.motion_valid};

  always_comb begin
    s_d       = s_q;
    mem_we    = 1'b0;
    mem_addr  = i_avs_address[8:2];
    mem_wdata = i_avs_writedata[7:0];
    wr_go     = 1'b0;
    wr_a      = link_wr_addr;
    wr_v      = link_wr_data;

    // Toggle events from the serial clock domain, only the last two stages are read
    s_d.wr_sync = {s_q.wr_sync[1:0], link_wr_tog};
    s_d.rd_sync = {s_q.rd_sync[1:0], link_rd_tog};
    spi_wr = s_q.wr_sync[1] ^ s_q.wr_sync[2];
    spi_rd = s_q.rd_sync[1] ^ s_q.rd_sync[2];

    // Read byte is ready a few cycles after the address, well inside the gap
    if (s_q.rd_pend) begin
      s_d.rd_hold = mem_rdata;
      s_d.rd_pend = 1'b0;
    end

    // Serial accesses take the storage port first, the bus waits
    if (spi_wr) begin
      if (s_q.ctrl[`CFG_SPI_EN_BIT]) begin
        mem_we      = 1'b1;
        mem_addr    = link_wr_addr;
        mem_wdata   = link_wr_data;
        wr_go       = 1'b1;
        s_d.last_wr = link_wr_addr;
      end
    end else if (spi_rd) begin
      mem_addr    = link_rd_addr;
      s_d.rd_pend = 1'b1;
    end

    case (s_q.av)
      sensor_serial_pkg::AV_IDLE: begin
        if (av_req && !spi_wr && !spi_rd) begin
          s_d.av = sensor_serial_pkg::AV_WAIT;
        end
      end
      sensor_serial_pkg::AV_WAIT: begin
        if (!av_own) begin
          s_d.av_rdata = {24'h00_0000, mem_rdata};
        end else if (i_avs_address == `CFG_AV_STATUS) begin
          s_d.av_rdata = status_word;
        end else if (i_avs_address == `CFG_AV_CONTROL) begin
          s_d.av_rdata = {24'h00_0000, s_q.ctrl};
        end else begin
          // Unmapped own addresses read zero and ignore writes
          s_d.av_rdata = 32'h0000_0000;
        end
        s_d.av = sensor_serial_pkg::AV_DONE;
      end
      sensor_serial_pkg::AV_DONE: begin
        // Bus write lands on the answer edge only, never ahead of it
        if (!spi_wr && !spi_rd) begin
          if (!av_own) begin
            if (i_avs_write && i_avs_byteenable[0]) begin
              mem_we    = 1'b1;
              wr_go     = 1'b1;
              wr_a      = i_avs_address[8:2];
              wr_v      = i_avs_writedata[7:0];
            end
          end else if (i_avs_write && i_avs_byteenable[0] &&
                       i_avs_address == `CFG_AV_CONTROL) begin
            s_d.ctrl = i_avs_writedata[7:0];
          end
          s_d.av = sensor_serial_pkg::AV_IDLE;
        end
      end
      default: begin
        s_d.av = sensor_serial_pkg::AV_IDLE;
      end
    endcase

    if (s_q.cnt != 27'h000_0000) begin
      s_d.cnt = s_q.cnt - 27'h000_0001;
    end

    // Power state timing; power-down outranks forced rest
    case (s_q.st)
      sensor_serial_pkg::PWR_RESETTING: begin
        if (s_q.cnt == 27'h000_0000) begin
          s_d.st = sensor_serial_pkg::PWR_RUN;
        end
      end
      sensor_serial_pkg::PWR_RUN: begin
        if (s_q.pc[`CFG_PD_BIT]) begin
          s_d.st  = sensor_serial_pkg::PWR_DOWN_ENTER;
          s_d.cnt = LD_PD;
        end else if (s_q.pc[`CFG_REST_LSB +: 2] != 2'h0) begin
          s_d.st  = sensor_serial_pkg::PWR_REST_ENTER;
          s_d.cnt = LD_REST_EN;
        end
      end
      sensor_serial_pkg::PWR_REST_ENTER, sensor_serial_pkg::PWR_REST: begin
        if (s_q.pc[`CFG_PD_BIT]) begin
          s_d.st  = sensor_serial_pkg::PWR_DOWN_ENTER;
          s_d.cnt = LD_PD;
        end else if (s_q.pc[`CFG_REST_LSB +: 2] == 2'h0) begin
          s_d.st  = sensor_serial_pkg::PWR_REST_EXIT;
          s_d.cnt = LD_REST_DIS;
        end else if (s_q.cnt == 27'h000_0000) begin
          s_d.st = sensor_serial_pkg::PWR_REST;
        end
      end
      sensor_serial_pkg::PWR_REST_EXIT: begin
        if (s_q.pc[`CFG_PD_BIT]) begin
          s_d.st  = sensor_serial_pkg::PWR_DOWN_ENTER;
          s_d.cnt = LD_PD;
        end else if (s_q.cnt == 27'h000_0000) begin
          s_d.st = sensor_serial_pkg::PWR_RUN;
        end
      end
      sensor_serial_pkg::PWR_DOWN_ENTER: begin
        if (s_q.cnt == 27'h000_0000) begin
          s_d.st = sensor_serial_pkg::PWR_DOWN;
        end
      end
      sensor_serial_pkg::PWR_DOWN: begin
        s_d.st = sensor_serial_pkg::PWR_DOWN;
      end
      sensor_serial_pkg::PWR_WAKE: begin
        if (s_q.cnt == 27'h000_0000) begin
          s_d.st = sensor_serial_pkg::PWR_RUN;
        end
      end
      default: begin
        s_d.st = sensor_serial_pkg::PWR_RESETTING;
      end
    endcase

    // Register write side effects override the timing machine
    if (wr_go) begin
      if (reg_hit(wr_a, `CFG_REG_POWER_CTL)) begin
        s_d.pc = wr_v;
      end
      if (reg_hit(wr_a, `CFG_REG_POWER_WAKE) && wr_v == `CFG_WAKE_KEY &&
          (s_q.st == sensor_serial_pkg::PWR_DOWN ||
           s_q.st == sensor_serial_pkg::PWR_DOWN_ENTER)) begin
        s_d.st              = sensor_serial_pkg::PWR_WAKE;
        s_d.cnt             = LD_WAKE;
        s_d.pc[`CFG_PD_BIT] = 1'b0;
      end
      if (reg_hit(wr_a, `CFG_REG_SOFT_RESET)) begin
        s_d.st  = sensor_serial_pkg::PWR_RESETTING;
        s_d.cnt = LD_MOT_RST;
        s_d.pc  = `CFG_PC_RESET;
      end
    end

    s_d.motion_valid = (s_d.st == sensor_serial_pkg::PWR_RUN);
    s_d.low_current  = (s_d.st == sensor_serial_pkg::PWR_DOWN);
    s_d.rest_active  = (s_d.st == sensor_serial_pkg::PWR_REST);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s_q <= CORE_RST;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata    = s_q.av_rdata;
  // A serial event owns the storage port, so it stalls the answer a cycle
  assign o_avs_waitrequest = (s_q.av != sensor_serial_pkg::AV_DONE) | spi_wr | spi_rd;
  assign o_motion_valid    = s_q.motion_valid;
  assign o_low_current     = s_q.low_current;
  assign o_rest_active     = s_q.rest_active;
endmodule
`default_nettype wire

// file: verilog/sensor_serial_cfg.svh
// Constants for the sensor serial port and power timing block
`ifndef SENSOR_SERIAL_CFG_SVH
`define SENSOR_SERIAL_CFG_SVH
`define CFG_CLK_MHZ        100
`define CFG_T_MOT_RST_MS   50
`define CFG_T_REST_EN_S    1
`define CFG_T_REST_DIS_S   1
`define CFG_T_PD_MS        50
`define CFG_T_WAKE_MS      50
`define CFG_T_WAKE_MAX_MS  55
`define CFG_MOT_RST_CYC    (`CFG_T_MOT_RST_MS * 1000 * `CFG_CLK_MHZ)
`define CFG_REST_EN_CYC    (`CFG_T_REST_EN_S * 1000000 * `CFG_CLK_MHZ)
`define CFG_REST_DIS_CYC   (`CFG_T_REST_DIS_S * 1000000 * `CFG_CLK_MHZ)
`define CFG_PD_CYC         (`CFG_T_PD_MS * 1000 * `CFG_CLK_MHZ)
`define CFG_WAKE_CYC       (`CFG_T_WAKE_MS * 1000 * `CFG_CLK_MHZ)
`define CFG_SYNC_MARGIN    8
`define CFG_REG_POWER_CTL  7'h0d
`define CFG_REG_POWER_WAKE 7'h3a
`define CFG_REG_SOFT_RESET 7'h3e
`define CFG_WAKE_KEY       8'h5a
`define CFG_PD_BIT         1
`define CFG_REST_LSB       2
`define CFG_PC_RESET       8'h00
`define CFG_AV_OWN_BIT     9
`define CFG_AV_STATUS      10'h200
`define CFG_AV_CONTROL     10'h204
`define CFG_CONTROL_RESET  8'h01
`define CFG_SPI_EN_BIT     0
`define CFG_LAST_ADDR_BIT  5'h07
`define CFG_FIRST_DATA     5'h08
`define CFG_LAST_DATA_BIT  5'h0f
`define CFG_FRAME_BITS     5'h10
`endif

// file: verilog/sensor_serial_pkg.sv
// Types shared by the sensor serial port and power timing block
`default_nettype none
package sensor_serial_pkg;
  typedef enum logic [2:0] {
    PWR_RESETTING, PWR_RUN, PWR_REST_ENTER, PWR_REST, PWR_REST_EXIT,
    PWR_DOWN_ENTER, PWR_DOWN, PWR_WAKE
  } power_state_t;
  typedef enum logic [1:0] {AV_IDLE, AV_WAIT, AV_DONE} av_state_t;
  typedef struct packed {
    logic [4:0] cnt;
    logic       is_write;
    logic [7:0] sh;
    logic [6:0] addr;
  } link_rise_t;
  typedef struct packed {
    logic       wr_tog;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic       rd_tog;
    logic [6:0] rd_addr;
  } link_event_t;
  typedef struct packed {
    logic       miso;
    logic       drive;
    logic [7:0] hold;
  } link_fall_t;
  typedef struct packed {
    logic [127:0][7:0] cells;
    logic [7:0]        rd_data;
  } mem_t;
  typedef struct packed {
    power_state_t st;
    logic [26:0]  cnt;
    logic [7:0]   pc;
    logic [7:0]   ctrl;
    logic [2:0]   wr_sync;
    logic [2:0]   rd_sync;
    av_state_t    av;
    logic         rd_pend;
    logic [7:0]   rd_hold;
    logic [31:0]  av_rdata;
    logic [6:0]   last_wr;
    logic         motion_valid;
    logic         low_current;
    logic         rest_active;
  } core_t;
endpackage
`default_nettype wire

// file: verilog/sensor_serial_mem.sv
// Register storage for the serial address space, registered read port
`timescale 1ns/1ns
`default_nettype none
module sensor_serial_mem (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic       i_wr_en,
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  output logic      [7:0] o_rd_data
);
  sensor_serial_pkg::mem_t m_q;
  sensor_serial_pkg::mem_t m_d;

  // Read before write: a same-cycle write shows on the next access
  always_comb begin
    m_d = m_q;
    m_d.rd_data = m_q.cells[i_addr];
    if (i_wr_en) begin
      m_d.cells[i_addr] = i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      m_q <= '0;
    end else if (i_clk_en) begin
      m_q <= m_d;
    end
  end

  assign o_rd_data = m_q.rd_data;
endmodule
`default_nettype wire

// file: verilog/sensor_serial_link.sv
// Serial pin side, clocked by the host's serial clock
`timescale 1ns/1ns
`default_nettype none
`include "sensor_serial_cfg.svh"
module sensor_serial_link (
  input  wire logic       i_sclk,
  input  wire logic       i_reset,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_mosi,
  input  wire logic [7:0] i_rd_data,
  output logic            o_miso,
  output logic            o_miso_oe_n,
  output logic            o_wr_toggle,
  output logic      [6:0] o_wr_addr,
  output logic      [7:0] o_wr_data,
  output logic            o_rd_toggle,
  output logic      [6:0] o_rd_addr
);
  sensor_serial_pkg::link_rise_t  r_q;
  sensor_serial_pkg::link_rise_t  r_d;
  sensor_serial_pkg::link_event_t e_q;
  sensor_serial_pkg::link_event_t e_d;
  sensor_serial_pkg::link_fall_t  f_q;
  sensor_serial_pkg::link_fall_t  f_d;

  // Rising edge: sample host data, address byte then data byte
  always_comb begin
    r_d = r_q;
    e_d = e_q;
    r_d.sh = {r_q.sh[6:0], i_mosi};
    if (r_q.cnt == 5'h00) begin
      r_d.is_write = i_mosi;
    end
    if (r_q.cnt != `CFG_FRAME_BITS) begin
      r_d.cnt = r_q.cnt + 5'h01;
    end
    if (r_q.cnt == `CFG_LAST_ADDR_BIT) begin
      r_d.addr = {r_q.sh[5:0], i_mosi};
      if (!r_q.is_write) begin
        e_d.rd_addr = {r_q.sh[5:0], i_mosi};
        e_d.rd_tog  = ~e_q.rd_tog;
      end
    end
    if (r_q.cnt == `CFG_LAST_DATA_BIT && r_q.is_write) begin
      e_d.wr_addr = r_q.addr;
      e_d.wr_data = {r_q.sh[6:0], i_mosi};
      e_d.wr_tog  = ~e_q.wr_tog;
    end
  end

  // Falling edge: shift the read byte out, MSB first
  always_comb begin
    f_d = f_q;
    if (r_q.cnt == `CFG_FIRST_DATA && !r_q.is_write && !f_q.drive) begin
      f_d.hold  = i_rd_data;
      f_d.miso  = i_rd_data[7];
      f_d.drive = 1'b1;
    end else if (f_q.drive && !r_q.cnt[4]) begin
      f_d.miso = f_q.hold[3'(4'hf - r_q.cnt[3:0])];
    end
  end

  // Frame state ends with the frame, the clock may stop afterwards
  always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(negedge i_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // Events must survive the frame end, so only the core reset clears them
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      e_q <= '0;
    end else begin
      e_q <= e_d;
    end
  end

  assign o_miso      = f_q.miso;
  assign o_miso_oe_n = i_chip_select_n | ~f_q.drive;
  assign o_wr_toggle = e_q.wr_tog;
  assign o_wr_addr   = e_q.wr_addr;
  assign o_wr_data   = e_q.wr_data;
  assign o_rd_toggle = e_q.rd_tog;
  assign o_rd_addr   = e_q.rd_addr;
endmodule
`default_nettype wire

// file: verif/sensor_serial_port_assertions.sv
// Concurrent checks on the sensor serial port top level
`timescale 1ns/1ns
`default_nettype none
module sensor_serial_port_assertions #(
  parameter int P_MOT_RST_CYC  = 64,
  parameter int P_REST_EN_CYC  = 64,
  parameter int P_REST_DIS_CYC = 64,
  parameter int P_PD_CYC       = 64,
  parameter int P_WAKE_CYC     = 64
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic o_miso,
  input wire logic o_miso_oe_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_motion_valid,
  input wire logic o_low_current,
  input wire logic o_rest_active
);
  localparam int WAKE_LO = P_WAKE_CYC - 3;
  localparam int WAKE_HI = P_WAKE_CYC * 11 / 10 + 2;
  // Loose on purpose: one bound for every route back to run
  localparam int MOT_HI  = P_MOT_RST_CYC + P_REST_DIS_CYC + P_WAKE_CYC;
  logic [2:0]  prev_q;
  logic [31:0] cnt_q;
  logic        woke_q;
  wire  logic [2:0] stat = {o_rest_active, o_low_current, o_motion_valid};
  // Cycles since the last change of any power status output
  always_ff @(posedge i_ref_clk) begin
    prev_q <= stat;
    if (i_reset || prev_q != stat) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q != 32'hffff_ffff) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
    if (i_reset || (!prev_q[0] && stat[0])) begin
      woke_q <= 1'b0;
    end else if (prev_q[1] && !stat[1]) begin
      woke_q <= 1'b1;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_miso_release: assert property (i_chip_select_n |-> o_miso_oe_n)
    else $error("serial output driven while deselected");
  a_miso_edge: assert property (!o_miso_oe_n && $changed(o_miso) |-> !i_sclk)
    else $error("serial output changed outside the low clock phase");
  a_miso_hold: assert property (!o_miso_oe_n && !$past(o_miso_oe_n) && i_sclk && $past(i_sclk)
    |-> $stable(o_miso))
    else $error("serial output changed while clock high");
  a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (!o_avs_waitrequest |-> i_avs_read || i_avs_write)
    else $error("answer without a request");
  a_answer_bound: assert property ($rose(i_avs_read || i_avs_write)
    |-> o_avs_waitrequest[*2] ##[1:10] !o_avs_waitrequest)
    else $error("bus answer too early or too late");
  a_pd_time: assert property ($rose(o_low_current) |-> cnt_q <= P_PD_CYC + 8)
    else $error("power-down reached too late");
  a_rest_time: assert property ($rose(o_rest_active) |-> cnt_q <= P_REST_EN_CYC + 8)
    else $error("forced rest reached too late");
  a_wake_window: assert property ($rose(o_motion_valid) && woke_q
    |-> cnt_q >= WAKE_LO && cnt_q <= WAKE_HI)
    else $error("wake delay outside its window");
  a_motion_bound: assert property ($rose(o_motion_valid) |-> cnt_q <= MOT_HI)
    else $error("motion valid too late");
  a_run_exclusive: assert property (o_motion_valid |-> !o_low_current && !o_rest_active)
    else $error("run state overlaps a low power state");
endmodule
bind sensor_serial_port sensor_serial_port_assertions #(
  .P_MOT_RST_CYC  (P_MOT_RST_CYC),
  .P_REST_EN_CYC  (P_REST_EN_CYC),
  .P_REST_DIS_CYC (P_REST_DIS_CYC),
  .P_PD_CYC       (P_PD_CYC),
  .P_WAKE_CYC     (P_WAKE_CYC)
) u_sensor_serial_port_assertions (
  .i_ref_clk (i_ref_clk), .i_reset (i_reset), .i_sclk (i_sclk),
  .i_chip_select_n (i_chip_select_n), .o_miso (o_miso), .o_miso_oe_n (o_miso_oe_n),
  .i_avs_read (i_avs_read), .i_avs_write (i_avs_write), .o_avs_waitrequest (o_avs_waitrequest),
  .o_motion_valid (o_motion_valid), .o_low_current (o_low_current), .o_rest_active (o_rest_active)
);
`default_nettype wire

// file: verif/spi_host_model.sv
// Host controller model driving the serial port frames
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic i_miso,
  input  wire logic i_miso_oe_n,
  output logic      o_sclk,
  output logic      o_chip_select_n,
  output logic      o_mosi
);
  logic last_q = 1'b0;
  int   gap_ns = 0;
  // Released line floats: show the inverse of the last driven bit
  always @(i_miso or i_miso_oe_n) if (!i_miso_oe_n) last_q = i_miso;
  wire logic miso_line = i_miso_oe_n ? ~last_q : i_miso;
  // Clock stands high between frames
  initial begin
    o_sclk = 1'b1;
    o_chip_select_n = 1'b1;
    o_mosi = 1'b1;
  end
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {wr, addr, wdat};
    rdat = 8'h00;
    #3 o_chip_select_n = 1'b0;
    #150;
    for (int i = 15; i >= 0; i--) begin
      if (i == 7 && !wr) #4000;
      o_sclk = 1'b0;
      o_mosi = (wr || i > 7) ? frame[i] : ~o_mosi;
      #15 o_sclk = 1'b1;
      if (i < 8) rdat[i] = miso_line;
      #15;
    end
    #(wr ? 20050 : 150) o_chip_select_n = 1'b1;
    #(wr ? 10000 : 300);
    #(gap_ns);
  endtask
endmodule
`default_nettype wire

// file: verif/sensor_serial_port_power_timing_bench.sv
// Self-checking bench for the sensor serial port and power timing block
`timescale 1ns/1ns
`default_nettype none
module sensor_serial_port_power_timing_bench;
  localparam int P_MOT = 100;
  localparam int P_REST = 120;
  localparam int P_PD = 100;
  localparam int P_WAKE = 100;
  typedef struct packed {
    logic        wr;
    logic [9:0]  addr;
    logic [3:0]  be;
    logic [31:0] data;
    logic [31:0] exp;
  } av_row_t;
  logic        i_ref_clk        = 1'b0;
  logic        i_reset          = 1'b1;
  logic        i_avs_read       = 1'b0;
  logic        i_avs_write      = 1'b0;
  logic [9:0]  i_avs_address    = 10'h000;
  logic [31:0] i_avs_writedata  = 32'h0000_0000;
  logic [3:0]  i_avs_byteenable = 4'hf;
  logic        i_sclk, i_chip_select_n, i_mosi, o_miso, o_miso_oe_n, o_avs_waitrequest;
  logic        o_motion_valid, o_low_current, o_rest_active;
  logic [31:0] o_avs_readdata, q;
  logic [7:0]  sq;
  int          failures = 0;
  int          compares = 0;
  int          n;
  wire logic [2:0] status_w = {o_rest_active, o_low_current, o_motion_valid};
  av_row_t rows [8] = '{
    '{1'b0, 10'h204, 4'hf, 32'h0000_0000, 32'h0000_0001},
    '{1'b1, 10'h040, 4'hf, 32'h0000_00a5, 32'h0000_0000},
    '{1'b0, 10'h040, 4'hf, 32'h0000_0000, 32'h0000_00a5},
    '{1'b1, 10'h044, 4'he, 32'h0000_0077, 32'h0000_0000},
    '{1'b0, 10'h044, 4'hf, 32'h0000_0000, 32'h0000_0000},
    '{1'b1, 10'h208, 4'hf, 32'h0000_00ff, 32'h0000_0000},
    '{1'b0, 10'h208, 4'hf, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, 10'h204, 4'hf, 32'h0000_0000, 32'h0000_0001}
  };
  always #5 i_ref_clk = ~i_ref_clk;
  sensor_serial_port #(
    .P_MOT_RST_CYC (P_MOT), .P_REST_EN_CYC (P_REST), .P_REST_DIS_CYC (P_REST),
    .P_PD_CYC (P_PD), .P_WAKE_CYC (P_WAKE)
  ) u_sensor_serial_port (
    .i_ref_clk (i_ref_clk), .i_reset (i_reset), .i_clk_en (1'b1), .i_sclk (i_sclk),
    .i_chip_select_n (i_chip_select_n), .i_mosi (i_mosi), .o_miso (o_miso),
    .o_miso_oe_n (o_miso_oe_n), .i_avs_address (i_avs_address), .i_avs_read (i_avs_read),
    .i_avs_write (i_avs_write), .i_avs_writedata (i_avs_writedata),
    .i_avs_byteenable (i_avs_byteenable), .o_avs_readdata (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest), .o_motion_valid (o_motion_valid),
    .o_low_current (o_low_current), .o_rest_active (o_rest_active)
  );
  spi_host_model u_spi_host_model (
    .i_miso (o_miso), .i_miso_oe_n (o_miso_oe_n), .o_sclk (i_sclk),
    .o_chip_select_n (i_chip_select_n), .o_mosi (i_mosi)
  );
  task automatic check(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic av(input logic wr, input logic [9:0] a, input logic [3:0] be,
                    input logic [31:0] d, output logic [31:0] rd);
    int k;
    @(posedge i_ref_clk);
    i_avs_address    <= a;
    i_avs_write      <= wr;
    i_avs_read       <= ~wr;
    i_avs_byteenable <= be;
    i_avs_writedata  <= d;
    for (k = 0; k < 40; k++) begin
      @(posedge i_ref_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    check(k < 40, "bus answer missing");
    if (k >= 40) conclude();
  endtask
  task automatic wait_for(input int sel, input logic v, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge i_ref_clk);
      #1;
      if (status_w[sel] === v) break;
    end
    check(cnt < lim, "status wait ran out");
    if (cnt >= lim) conclude();
  endtask
  initial begin
    #900_000;
    failures++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    check(o_avs_waitrequest === 1'b1 && status_w === 3'b000 && o_miso_oe_n === 1'b1, "reset");
    wait_for(0, 1'b1, P_MOT + 4, n);
    foreach (rows[i]) begin
      av(rows[i].wr, rows[i].addr, rows[i].be, rows[i].data, q);
      if (!rows[i].wr) check(q === rows[i].exp, "bus read value");
    end
    u_spi_host_model.xfer(1'b0, 7'h10, 8'h00, sq);
    check(sq === 8'ha5, "serial read value");
    u_spi_host_model.xfer(1'b1, 7'h20, 8'h3c, sq);
    av(1'b0, 10'h080, 4'hf, 32'h0000_0000, q);
    check(q === 32'h0000_003c, "serial write lost");
    av(1'b0, 10'h200, 4'hf, 32'h0000_0000, q);
    check((q & 32'h0000_7f07) === 32'h0000_2001, "status after write");
    check(o_miso_oe_n === 1'b1, "output not released");
    // Serial writes blocked while the control enable is clear
    av(1'b1, 10'h204, 4'hf, 32'h0000_0000, q);
    u_spi_host_model.xfer(1'b1, 7'h21, 8'h55, sq);
    av(1'b0, 10'h084, 4'hf, 32'h0000_0000, q);
    check(q === 32'h0000_0000, "serial write not blocked");
    av(1'b1, 10'h204, 4'hf, 32'h0000_0001, q);
    fork
      u_spi_host_model.xfer(1'b1, 7'h0d, 8'h02, sq);
      begin
        wait_for(0, 1'b0, 800, n);
        wait_for(1, 1'b1, P_PD + 4, n);
      end
    join
    // Wrong key must leave the block asleep
    u_spi_host_model.xfer(1'b1, 7'h3a, 8'h5b, sq);
    check(status_w === 3'b010, "woke on a wrong key");
    fork
      u_spi_host_model.xfer(1'b1, 7'h3a, 8'h5a, sq);
      begin
        wait_for(1, 1'b0, 800, n);
        wait_for(0, 1'b1, P_WAKE * 2, n);
        check(n >= P_WAKE - 3 && n <= P_WAKE * 11 / 10, "wake delay");
      end
    join
    u_spi_host_model.gap_ns = 2000;
    for (int m = 1; m < 4; m++) begin
      fork
        u_spi_host_model.xfer(1'b1, 7'h0d, {4'h0, m[1:0], 2'b00}, sq);
        wait_for(2, 1'b1, 800 + P_REST, n);
      join
      fork
        u_spi_host_model.xfer(1'b1, 7'h0d, 8'h00, sq);
        begin
          wait_for(2, 1'b0, 800, n);
          wait_for(0, 1'b1, P_REST + 4, n);
        end
      join
    end
    fork
      u_spi_host_model.xfer(1'b1, 7'h3e, 8'h00, sq);
      begin
        wait_for(0, 1'b0, 800, n);
        wait_for(0, 1'b1, P_MOT + 4, n);
      end
    join
    conclude();
  end
endmodule
`default_nettype wire
